// *** src/eeprom_device.sv ***
/*
 EEPROM device end: command layer on the link clock, programming on mclk.
 Assumes the master drives the clock and keeps to the two-wire protocol.
*/
`timescale 1ns/10ps
`default_nettype none

`include "eeprom_cfg.svh"

// Behaviour
// - Two address bytes after device address, each acked
// - Master stops right after single data ack
// - Stop starts programming; link ignored until done
// - Page write data byte acknowledged only while the write is allowed
// - Page write bumps seven low bits, wraps
// - Polled device address acked only when idle
// - Identification page write uses page protocol
// - Locked identification page: data not acked
// - Lock command sets permanent read-only state
// - Read direction bit one; three read forms
// - Counter holds last address plus one
// - Read increment wraps from top to zero
// - Current read returns byte at counter
// - Dummy write loads address for random read
// - Master ack continues, nack ends read
// - Identification page readable by normal reads
// - Master keeps identification reads inside page
// - Lock status shown by data byte ack
// - Type code and direction bit checked
// - Select bits must match pins, else standby
// - Ack drives data low on ninth clock
// - Write inhibit high blocks array writes
module eeprom_device import eeprom_pkg::*; (
	// System
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// Link
	eeprom_link_if.device link,
	// Pins
	input wire logic chip_select_pin_high,
	input wire logic chip_select_pin_mid,
	input wire logic chip_select_pin_low,
	input wire logic write_inhibit_pin,
	// Status
	output logic busy,
	output logic id_locked
);

	// ==========================================
	// Storage
	logic [7:0] mem [65536]; // Main array, written on mclk only
	logic [7:0] id_mem [128]; // Identification page
	logic [7:0] page_buf [128]; // Bytes of one write frame

	// ==========================================
	// Link side state
	logic start_tog_q; // Start events, on data fall
	logic stop_tog_q; // Stop events, on data rise
	logic commit_tog_q; // Accepted writes
	logic start_seen_q;
	logic stop_seen_q;
	link_state_t st_q;
	link_state_t nxt_q; // State after ack slot
	logic [3:0] bitcnt_q;
	logic [7:0] shift_q;
	logic [7:0] rd_q; // Byte being sent
	logic ack_q; // Ack decided for this byte
	logic id_q; // Identification type code
	logic [7:0] addr_hi_q;
	logic [15:0] cnt_q; // Word address counter
	wr_kind_t kind_q;
	logic armed_q; // Frame holds a write to commit
	logic arm_start_q; // Start that armed it
	logic [127:0] page_vld_q;
	logic sda_oe_n_q; // Data enable, low while pulling the line
	logic [1:0] done_sync_q;
	logic [1:0] lock_sync_q;
	logic [1:0] wi_sync_q;
	logic [2:0] cs_sync1_q;
	logic [2:0] cs_sync2_q;

	// ==========================================
	// System side state
	prog_state_t ps_q;
	logic [1:0] commit_sync_q;
	logic done_tog_q;
	logic [6:0] copy_idx_q;
	logic [15:0] timer_q;
	logic locked_q;
	logic busy_q;

	// ==========================================
	// Decoding
	wire [7:0] byte_w = {shift_q[6:0], link.sda};
	wire new_start = (start_tog_q != start_seen_q);
	wire new_stop = (stop_tog_q != stop_seen_q);
	// Busy from stop until the system side hands back
	wire busy_link = commit_tog_q ^ done_sync_q[1];
	wire dev_match = (byte_w[7:5] == `TYPE_CODE_BASE) && (byte_w[3:1] == cs_sync2_q) && !busy_link;
	wire recv_st = (st_q == LS_DEVADDR) || (st_q == LS_ADDRH) || (st_q == LS_ADDRL) || (st_q == LS_WDATA);
	wire wr_ok = (kind_q == WK_ARRAY) ? !wi_sync_q[1] :
		(kind_q == WK_NONE) ? 1'b0 : !lock_sync_q[1];
	wire [7:0] rd_data = id_q ? id_mem[cnt_q[6:0]] : mem[cnt_q];
	wire [15:0] cnt_page = {cnt_q[15:7], cnt_q[6:0] + 7'h01};
	wire drv_d = (recv_st && bitcnt_q == 4'h8 && ack_q) ||
		(st_q == LS_RDATA && bitcnt_q != 4'h8 && !rd_q[~bitcnt_q[2:0]]);

	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe_n = sda_oe_n_q;
	assign busy = busy_q;
	assign id_locked = locked_q;

	// ==========================================
	// Start and stop, clocked by the data line
	always_ff @(negedge link.sda or negedge resetn) begin
		if (!resetn) begin
			start_tog_q <= 1'b0;
		end else if (link.scl) begin
			start_tog_q <= !start_tog_q;
		end
	end

	// Commit only if no start came after arming
	always_ff @(posedge link.sda or negedge resetn) begin
		if (!resetn) begin
			stop_tog_q <= 1'b0;
			commit_tog_q <= 1'b0;
		end else if (link.scl) begin
			stop_tog_q <= !stop_tog_q;
			if (armed_q && arm_start_q == start_tog_q && !busy_link) begin
				commit_tog_q <= !commit_tog_q;
			end
		end
	end

	// ==========================================
	// Pin and status synchronisers on the link clock
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			done_sync_q <= 2'h0;
			lock_sync_q <= 2'h0;
			wi_sync_q <= 2'h0;
			cs_sync1_q <= 3'h0;
			cs_sync2_q <= 3'h0;
		end else begin
			done_sync_q <= {done_sync_q[0], done_tog_q};
			lock_sync_q <= {lock_sync_q[0], locked_q};
			wi_sync_q <= {wi_sync_q[0], write_inhibit_pin};
			cs_sync1_q <= {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
			cs_sync2_q <= cs_sync1_q;
		end
	end

	// ==========================================
	// Byte engine: sample on rising clock
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
			st_q <= LS_IDLE;
			nxt_q <= LS_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			rd_q <= 8'hFF;
			ack_q <= 1'b0;
			id_q <= 1'b0;
			addr_hi_q <= 8'h00;
			cnt_q <= 16'h0000;
			kind_q <= WK_NONE;
			armed_q <= 1'b0;
			arm_start_q <= 1'b0;
			page_vld_q <= '0;
		end else begin
			start_seen_q <= start_tog_q;
			stop_seen_q <= stop_tog_q;
			if (new_start) begin
				// First bit of the device address
				st_q <= LS_DEVADDR;
				bitcnt_q <= 4'h1;
				shift_q <= {7'h00, link.sda};
				armed_q <= 1'b0;
			end else if (new_stop) begin
				st_q <= LS_IDLE;
			end else if (st_q == LS_IDLE || st_q == LS_IGNORE) begin
				bitcnt_q <= 4'h0;
			end else if (bitcnt_q != 4'h8) begin
				bitcnt_q <= bitcnt_q + 4'h1;
				shift_q <= byte_w;
				if (bitcnt_q == 4'h7) begin
					case (st_q)
						LS_DEVADDR: begin
							ack_q <= dev_match;
							id_q <= byte_w[`TYPE_ID_BIT];
							nxt_q <= !dev_match ? LS_IGNORE : byte_w[`DIR_BIT] ? LS_RDATA : LS_ADDRH;
						end
						LS_ADDRH: begin
							addr_hi_q <= byte_w;
							ack_q <= 1'b1;
							nxt_q <= LS_ADDRL;
						end
						LS_ADDRL: begin
							cnt_q <= {addr_hi_q, byte_w};
							ack_q <= 1'b1;
							nxt_q <= LS_WDATA;
							page_vld_q <= '0;
							// Area from upper address bits
							kind_q <= !id_q ? WK_ARRAY : addr_hi_q[`ADDR_LOCK_BIT - 8] ? WK_LOCK :
								addr_hi_q[3] ? WK_NONE : WK_ID;
						end
						LS_WDATA: begin
							ack_q <= wr_ok;
							nxt_q <= wr_ok ? LS_WDATA : LS_IGNORE;
							if (wr_ok && kind_q == WK_LOCK) begin
								armed_q <= byte_w[`LOCK_DATA_BIT];
								arm_start_q <= start_tog_q;
							end else if (wr_ok) begin
								page_vld_q[cnt_q[6:0]] <= 1'b1;
								cnt_q <= cnt_page;
								armed_q <= 1'b1;
								arm_start_q <= start_tog_q;
							end
						end
						default: begin
							nxt_q <= nxt_q;
						end
					endcase
				end
			end else begin
				// Ack slot
				bitcnt_q <= 4'h0;
				if (st_q == LS_RDATA) begin
					if (!link.sda) begin
						rd_q <= rd_data;
						cnt_q <= cnt_q + 16'h0001;
					end else begin
						st_q <= LS_IGNORE;
					end
				end else begin
					st_q <= nxt_q;
					if (nxt_q == LS_RDATA) begin
						rd_q <= rd_data;
						cnt_q <= cnt_q + 16'h0001;
					end
				end
			end
		end
	end

	// Frame buffer, written beside the valid mask
	always_ff @(posedge link.scl) begin
		if (!new_start && st_q == LS_WDATA && bitcnt_q == 4'h7 && wr_ok) begin
			page_buf[cnt_q[6:0]] <= byte_w;
		end
	end

	// Data drive changes on falling clock
	always_ff @(negedge link.scl or negedge resetn) begin
		if (!resetn) begin
			sda_oe_n_q <= 1'b1;
		end else begin
			sda_oe_n_q <= !drv_d;
		end
	end

	// ==========================================
	// Programming on mclk; link side waits on the done toggle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			commit_sync_q <= 2'h0;
			ps_q <= PS_IDLE;
			done_tog_q <= 1'b0;
			copy_idx_q <= 7'h00;
			timer_q <= 16'h0000;
			locked_q <= `LOCK_RESET;
			busy_q <= 1'b0;
		end else if (ce) begin
			commit_sync_q <= {commit_sync_q[0], commit_tog_q};
			case (ps_q)
				PS_IDLE: begin
					if (commit_sync_q[1] != done_tog_q) begin
						busy_q <= 1'b1;
						copy_idx_q <= 7'h00;
						ps_q <= PS_COPY;
					end
				end
				PS_COPY: begin
					copy_idx_q <= copy_idx_q + 7'h01;
					if (kind_q == WK_LOCK) begin
						locked_q <= 1'b1;
					end
					if (kind_q == WK_LOCK || copy_idx_q == 7'h7F) begin
						timer_q <= 16'h0000;
						ps_q <= PS_WAIT;
					end
				end
				PS_WAIT: begin
					timer_q <= timer_q + 16'h0001;
					if (timer_q == 16'(`WRITE_CYCLE_CYC - 1)) begin
						done_tog_q <= commit_sync_q[1];
						busy_q <= 1'b0;
						ps_q <= PS_IDLE;
					end
				end
				default: begin
					ps_q <= PS_IDLE;
				end
			endcase
		end
	end

	// Copy valid bytes into their page
	always_ff @(posedge mclk) begin
		if (ce && ps_q == PS_COPY && page_vld_q[copy_idx_q]) begin
			if (kind_q == WK_ARRAY) begin
				mem[{cnt_q[15:7], copy_idx_q}] <= page_buf[copy_idx_q];
			end else if (kind_q == WK_ID) begin
				id_mem[copy_idx_q] <= page_buf[copy_idx_q];
			end
		end
	end

endmodule : eeprom_device

`default_nettype wire

// *** src/eeprom_cfg.svh ***
/*
 Constants of the serial EEPROM link: field positions, codes, timing.
 Assumes a 10 MHz system clock on both ends.
*/
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// ==========================================
// Timing
`define CLK_FREQ_KHZ 10000
`define SCL_FREQ_KHZ 100
// Quarter of a link bit in system cycles, rounded up
`define SCL_QUARTER_CYC ((`CLK_FREQ_KHZ + 4 * `SCL_FREQ_KHZ - 1) / (4 * `SCL_FREQ_KHZ))
`define WRITE_CYCLE_US 100
// Least programming time, rounded up
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_US * `CLK_FREQ_KHZ + 999) / 1000)

// ==========================================
// Device address fields
`define TYPE_CODE_BASE 3'h5
`define TYPE_ID_BIT 4
`define DIR_BIT 0

// ==========================================
// Word address and data fields
`define ADDR_LOCK_BIT 10
`define LOCK_DATA_BIT 1
`define LOCK_RESET 1'b0

`endif

// *** src/eeprom_pkg.sv ***
/*
 Types shared by both ends of the EEPROM link.
 Assumes nothing of its surroundings.
*/
package eeprom_pkg;

	// ==========================================
	// Device link states, Gray along the usual path
	typedef enum logic [2:0] {
		LS_IDLE = 3'h0,
		LS_DEVADDR = 3'h1,
		LS_ADDRH = 3'h3,
		LS_ADDRL = 3'h2,
		LS_WDATA = 3'h6,
		LS_RDATA = 3'h7,
		LS_IGNORE = 3'h4
	} link_state_t;

	// Programming states
	typedef enum logic [1:0] {
		PS_IDLE = 2'h0,
		PS_COPY = 2'h1,
		PS_WAIT = 2'h3
	} prog_state_t;

	// Kind of pending write
	typedef enum logic [1:0] {
		WK_NONE = 2'h0,
		WK_ARRAY = 2'h1,
		WK_ID = 2'h3,
		WK_LOCK = 2'h2
	} wr_kind_t;

	// Master byte-level operations
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h3,
		OP_STOP = 2'h2
	} bus_op_t;

	// Master states
	typedef enum logic [1:0] {
		MS_IDLE = 2'h0,
		MS_RUN = 2'h1,
		MS_DONE = 2'h3
	} master_state_t;

endpackage : eeprom_pkg

// *** src/eeprom_link_if.sv ***
/*
 Two-wire link between the EEPROM device and its bus master.
 Assumes the master alone drives the clock; data is wired-AND with pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

interface eeprom_link_if;
	// Clock from the master
	logic scl;
	// Open-drain data drivers, enable active low
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic mst_sda_o;
	logic mst_sda_oe_n;
	// Resolved data line, pulled high when released
	logic sda;

	assign sda = (dev_sda_oe_n | dev_sda_o) & (mst_sda_oe_n | mst_sda_o);

	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport master (output scl, input sda, output mst_sda_o, output mst_sda_oe_n);
endinterface : eeprom_link_if

`default_nettype wire

// *** src/eeprom_master.sv ***
/*
 Bus master end: runs start, stop, byte write and byte read on the link.
 Assumes the user sequences operations into whole transactions.
*/
`timescale 1ns/10ps
`default_nettype none

`include "eeprom_cfg.svh"

module eeprom_master import eeprom_pkg::*; (
	// System
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// Link
	eeprom_link_if.master link,
	// Command
	input wire logic cmd_valid,
	input wire bus_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_nack,
	output logic cmd_ready,
	// Response
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);

	localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYC);

	// ==========================================
	// State
	master_state_t ms_q; // Sequencer
	bus_op_t op_q; // Operation in flight
	logic [8:0] tx_q; // Bits to send, msb first
	logic [8:0] rx_q; // Bits seen
	logic [3:0] slot_q; // Bit slot
	logic [1:0] phase_q; // Quarter within slot
	logic [7:0] div_q; // Quarter divider
	logic scl_q; // Clock pin
	logic oe_n_q; // Data enable
	logic [1:0] sda_sync_q; // Pin synchroniser
	logic ready_q;
	logic rvalid_q;

	// ==========================================
	// Decoding
	wire tick = (div_q == QUARTER - 8'h01);
	wire bit_op = (op_q == OP_WRITE) || (op_q == OP_READ);
	wire scl_lvl = (phase_q == 2'h1) || (phase_q == 2'h2) || (op_q == OP_STOP && phase_q == 2'h3);
	wire sda_lvl = (op_q == OP_START) ? (phase_q < 2'h2) :
		(op_q == OP_STOP) ? (phase_q >= 2'h2) : tx_q[8];
	wire last = !bit_op || (slot_q == 4'h8);

	assign link.scl = scl_q;
	assign link.mst_sda_o = 1'b0;
	assign link.mst_sda_oe_n = oe_n_q;
	assign cmd_ready = ready_q;
	assign rsp_valid = rvalid_q;
	assign rsp_data = rx_q[8:1];
	assign rsp_nack = rx_q[0];

	// Data pin sampled through two flops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sda_sync_q <= 2'h0;
		end else if (ce) begin
			sda_sync_q <= {sda_sync_q[0], link.sda};
		end
	end

	// ==========================================
	// Sequencer; levels change on quarter ticks only
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ms_q <= MS_IDLE;
			op_q <= OP_STOP;
			tx_q <= 9'h1FF;
			rx_q <= 9'h000;
			slot_q <= 4'h0;
			phase_q <= 2'h0;
			div_q <= 8'h00;
			scl_q <= 1'b1;
			oe_n_q <= 1'b1;
			ready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= 1'b0;
			case (ms_q)
				MS_IDLE: begin
					if (cmd_valid && ready_q) begin
						op_q <= cmd_op;
						// Write releases the ack slot; read releases data bits
						tx_q <= (cmd_op == OP_READ) ? {8'hFF, cmd_nack} : {cmd_data, 1'b1};
						slot_q <= 4'h0;
						phase_q <= 2'h0;
						div_q <= 8'h00;
						ready_q <= 1'b0;
						ms_q <= MS_RUN;
					end
				end
				MS_RUN: begin
					div_q <= tick ? 8'h00 : div_q + 8'h01;
					if (tick) begin
						scl_q <= scl_lvl;
						oe_n_q <= sda_lvl;
						phase_q <= phase_q + 2'h1;
						// Sample mid-high, well after the device settled
						if (phase_q == 2'h2 && bit_op) begin
							rx_q <= {rx_q[7:0], sda_sync_q[1]};
						end
						if (phase_q == 2'h3) begin
							slot_q <= slot_q + 4'h1;
							tx_q <= {tx_q[7:0], 1'b1};
							if (last) begin
								ms_q <= MS_DONE;
							end
						end
					end
				end
				MS_DONE: begin
					rvalid_q <= 1'b1;
					ready_q <= 1'b1;
					ms_q <= MS_IDLE;
				end
				default: begin
					ms_q <= MS_IDLE;
				end
			endcase
		end
	end

endmodule : eeprom_master

`default_nettype wire

// *** tb/eeprom_link_chk.sv ***
/*
 Checker of the EEPROM link wires and the device status outputs.
 Assumes mclk samples the slow link clock often enough to see each edge.
*/
`timescale 1ns/10ps
`default_nettype none

`include "eeprom_cfg.svh"

module eeprom_link_chk (
	// System
	input wire logic mclk,
	input wire logic resetn,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic mst_sda_o,
	input wire logic mst_sda_oe_n,
	// Status
	input wire logic busy,
	input wire logic id_locked
);
	// Write cycle time; limit adds slack for the copy and the crossing
	localparam int PROG_MIN = `WRITE_CYCLE_CYC;
	localparam int PROG_MAX = `WRITE_CYCLE_CYC + 400;
	// ==========================================
	// Helper state
	logic scl_q;
	logic sda_q;
	logic [11:0] busy_cnt_q;
	logic [3:0] stop_age_q;
	wire logic stop_w = scl && scl_q && sda && !sda_q;
	wire logic [3:0] age_d = (stop_age_q == 4'hF) ? stop_age_q : stop_age_q + 4'h1;

	// Stop age saturates so a stale stop never looks recent
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy_cnt_q <= 12'h000;
			stop_age_q <= 4'hF;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			busy_cnt_q <= busy ? busy_cnt_q + 12'h001 : 12'h000;
			stop_age_q <= stop_w ? 4'h0 : age_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// Assertions
	a_ack_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data moved while clock high");
	a_ack_holds_high: assert property ($rose(scl) && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
		else $error("device pull dropped in clock high");
	a_drive_zero: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("device drives a one");
	a_mst_drive_zero: assert property (!mst_sda_oe_n |-> !mst_sda_o)
		else $error("master drives a one");
	a_busy_silent: assert property (busy |-> dev_sda_oe_n)
		else $error("device answered while programming");
	a_busy_from_stop: assert property ($rose(busy) |-> stop_age_q < 9)
		else $error("programming began without a stop");
	a_prog_min_len: assert property ($fell(busy) |-> busy_cnt_q >= PROG_MIN)
		else $error("programming ended too soon");
	a_prog_bounded: assert property (busy |-> busy_cnt_q < PROG_MAX)
		else $error("programming never ends");
	a_lock_sticky: assert property (id_locked |=> id_locked)
		else $error("lock state cleared");
	a_lock_on_commit: assert property ($rose(id_locked) |-> busy || $past(busy) || stop_age_q < 9)
		else $error("lock set outside a commit");
endmodule : eeprom_link_chk

`default_nettype wire

// *** tb/serial_eeprom_command_engine_tb.sv ***
/*
 Testbench: master and device joined by the link, driven at the master's user side.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_command_engine_tb import eeprom_pkg::*; ;
	// ==========================================
	// Signals
	logic mclk = 1'b0;
	// Starts high so the fall at 1 ns is an edge for every async flop
	logic resetn = 1'b1;
	logic cmd_valid = 1'b0;
	bus_op_t cmd_op = OP_START;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_nack = 1'b0;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_nack;
	logic [2:0] sel = 3'h5; // Select pins
	logic wr_inh = 1'b0;
	logic busy;
	logic id_locked;
	int fail_count = 0;
	int checked = 0;

	// Clock, 100 ns
	always #50 mclk = ~mclk;

	eeprom_link_if u_eeprom_link_if ();
	eeprom_master u_eeprom_master (.mclk(mclk), .resetn(resetn), .ce(1'b1), .link(u_eeprom_link_if),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	eeprom_device u_eeprom_device (.mclk(mclk), .resetn(resetn), .ce(1'b1), .link(u_eeprom_link_if),
		.chip_select_pin_high(sel[2]), .chip_select_pin_mid(sel[1]), .chip_select_pin_low(sel[0]),
		.write_inhibit_pin(wr_inh), .busy(busy), .id_locked(id_locked));
	eeprom_link_chk u_eeprom_link_chk (.mclk(mclk), .resetn(resetn), .scl(u_eeprom_link_if.scl),
		.sda(u_eeprom_link_if.sda), .dev_sda_o(u_eeprom_link_if.dev_sda_o),
		.dev_sda_oe_n(u_eeprom_link_if.dev_sda_oe_n), .mst_sda_o(u_eeprom_link_if.mst_sda_o),
		.mst_sda_oe_n(u_eeprom_link_if.mst_sda_oe_n), .busy(busy), .id_locked(id_locked));

	// ==========================================
	// Shared tasks
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One master operation, waits for its completion pulse
	task op(input bus_op_t o, input logic [7:0] d, input logic n);
		int i;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		cmd_nack = n;
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		chk({7'h00, cmd_ready}, 8'h00);
		for (i = 0; i < 1000 && rsp_valid !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({7'h00, rsp_valid}, 8'h01);
	endtask : op

	task wb(input logic [7:0] d, input logic n_exp);
		op(OP_WRITE, d, 1'b0);
		chk({7'h00, rsp_nack}, {7'h00, n_exp});
	endtask : wb

	task rb(input logic n, input logic [7:0] e);
		op(OP_READ, 8'h00, n);
		chk(rsp_data, e);
	endtask : rb

	function automatic logic [7:0] da(input logic id, input logic rw);
		return {3'h5, id, sel, rw};
	endfunction : da

	// Start, device address and both address bytes
	task addr(input logic id, input logic [15:0] a);
		op(OP_START, 8'h00, 1'b0);
		wb(da(id, 1'b0), 1'b0);
		wb(a[15:8], 1'b0);
		wb(a[7:0], 1'b0);
	endtask : addr

	task wr(input logic id, input logic [15:0] a, input logic [31:0] d, input int n, input logic ne);
		int i;
		addr(id, a);
		for (i = 0; i < n; i++) wb(d[31 - 8 * i -: 8], ne);
		op(OP_STOP, 8'h00, 1'b0);
	endtask : wr

	// Random or sequential read through a dummy write
	task rr(input logic id, input logic [15:0] a, input int n, input logic [31:0] e);
		int i;
		addr(id, a);
		op(OP_START, 8'h00, 1'b0);
		wb(da(id, 1'b1), 1'b0);
		for (i = 0; i < n; i++) rb(i == n - 1, e[31 - 8 * i -: 8]);
		op(OP_STOP, 8'h00, 1'b0);
	endtask : rr

	task wait_hi;
		int i;
		for (i = 0; i < 30 && busy !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({7'h00, busy}, 8'h01);
	endtask : wait_hi

	task wait_lo;
		int i;
		for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({7'h00, busy}, 8'h00);
	endtask : wait_lo

	task idle30;
		repeat (30) @(posedge mclk);
		#1;
	endtask : idle30

	// ==========================================
	// Scenarios
	task t_page_wrap;
		wr(1'b0, 16'h127D, 32'h11223344, 4, 1'b0);
		wait_hi;
		op(OP_START, 8'h00, 1'b0);
		wb(da(1'b0, 1'b0), 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		wait_lo;
		op(OP_START, 8'h00, 1'b0);
		wb(da(1'b0, 1'b0), 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		rr(1'b0, 16'h127D, 2, 32'h11220000);
		op(OP_START, 8'h00, 1'b0);
		wb(da(1'b0, 1'b1), 1'b0);
		rb(1'b1, 8'h33);
		op(OP_STOP, 8'h00, 1'b0);
		rr(1'b0, 16'h1200, 1, 32'h44000000);
		$display("test page_wrap done");
	endtask : t_page_wrap

	task t_top_wrap;
		wr(1'b0, 16'hFFFF, 32'hA5000000, 1, 1'b0);
		wait_hi;
		wait_lo;
		wr(1'b0, 16'h0000, 32'h5A000000, 1, 1'b0);
		wait_hi;
		wait_lo;
		rr(1'b0, 16'hFFFF, 2, 32'hA55A0000);
		$display("test top_wrap done");
	endtask : t_top_wrap

	task t_refuse;
		op(OP_START, 8'h00, 1'b0);
		wb({4'hA, 3'h2, 1'b0}, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		op(OP_START, 8'h00, 1'b0);
		wb(8'hEA, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
		wr_inh = 1'b1;
		wr(1'b0, 16'h1200, 32'h77000000, 1, 1'b1);
		wr(1'b1, 16'h0807, 32'h66000000, 1, 1'b1);
		idle30;
		chk({7'h00, busy}, 8'h00);
		wr_inh = 1'b0;
		rr(1'b0, 16'h1200, 1, 32'h44000000);
		$display("test refuse done");
	endtask : t_refuse

	task t_id_page;
		wr(1'b1, 16'hF385, 32'hC33C0000, 2, 1'b0);
		wait_hi;
		wait_lo;
		rr(1'b1, 16'h0005, 2, 32'hC33C0000);
		addr(1'b1, 16'h0005);
		wb(8'h99, 1'b0);
		op(OP_START, 8'h00, 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		idle30;
		chk({7'h00, busy}, 8'h00);
		addr(1'b1, 16'h0400);
		wb(8'h02, 1'b0);
		op(OP_START, 8'h00, 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		idle30;
		chk({7'h00, id_locked}, 8'h00);
		wr(1'b1, 16'h0400, 32'h02000000, 1, 1'b0);
		wait_hi;
		wait_lo;
		chk({7'h00, id_locked}, 8'h01);
		wr(1'b1, 16'h0005, 32'h55000000, 1, 1'b1);
		idle30;
		rr(1'b1, 16'h0005, 1, 32'hC3000000);
		$display("test id_page done");
	endtask : t_id_page

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		#1;
		resetn = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
		resetn = 1'b1;
		t_page_wrap;
		t_top_wrap;
		t_refuse;
		t_id_page;
		end_of_test;
	end

	// Watchdog: run needs about 85k cycles, limit kept under 100k
	initial begin
		#9500000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test;
	end
endmodule : serial_eeprom_command_engine_tb

`default_nettype wire
